// ---- dds_pkg.sv ----
// dds core constants, types and notes
package dds_pkg;
  localparam int unsigned ACC_W    = 64;
  localparam int unsigned SAMP_W   = 12;
  localparam int unsigned AW_S     = 14;
  localparam int unsigned AW_L     = 16;
  localparam int unsigned DEPTH_S  = 16384;
  localparam int unsigned DEPTH_L  = 65536;
  localparam int unsigned PTS_W    = 17;
  localparam int unsigned SAMP_MHZ = 200;
  // increment for 25 MHz, full scale * 25 / 200
  localparam logic [63:0] INC_ARB_MAX = 64'h2000_0000_0000_0000;
  // increment for 2 MHz, full scale * 2 / 200
  localparam logic [63:0] INC_SQ_CMP  = 64'h028F_5C28_F5C2_8F5C;
  localparam logic [11:0] LVL_MAX  = 12'hFFF;
  localparam logic [11:0] LVL_MIN  = 12'h000;
  localparam logic [7:0]  PLL_MIN  = 8'h64;
  localparam logic [7:0]  PLL_MAX  = 8'hC8;
  localparam int unsigned TRL_MAX_PS  = 10000;
  localparam int unsigned TRL_STEP_PS = 10;
  localparam logic [9:0]  TRL_MAX  = 10'(TRL_MAX_PS / TRL_STEP_PS);
  localparam logic [31:0] PER_RST  = 32'h0000_0064;
  localparam logic [31:0] WID_RST  = 32'h0000_0032;

  typedef enum logic [4:0] {
    FN_SINE = 5'h01, FN_STD = 5'h02, FN_ARB = 5'h04,
    FN_SQUARE = 5'h08, FN_PULSE = 5'h10
  } dds_func_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1, ST_FILL = 4'h2, ST_DDS = 4'h4, ST_PULSE = 4'h8
  } dds_state_t;

  typedef struct packed {
    logic [31:0] period;
    logic [31:0] width;
    logic [9:0]  trail;
    logic [7:0]  edge_t;
  } dds_pcfg_t;
endpackage : dds_pkg

// ---- dds_core.sv ----
// dds core: accumulator, waveform memory, fill, square and pulse paths
`timescale 1ns/1ns
module dds_core (
  input  wire logic              MCLK,
  input  wire logic              SYS_RST,
  input  wire dds_pkg::dds_func_t FUNC,
  input  wire logic              RUN,
  input  wire logic [63:0]       PHASE_INCREMENT_VALUE,
  input  wire logic              PHASE_LOAD,
  input  wire logic [11:0]       SQ_THRESHOLD,
  input  wire logic              LD_START,
  input  wire logic [16:0]       LD_POINTS,
  input  wire logic              LD_VALID,
  output logic                   LD_READY,
  input  wire logic [11:0]       LD_DATA,
  output logic                   LD_BUSY,
  input  wire dds_pkg::dds_pcfg_t PULSE_CFG,
  input  wire logic              PERIOD_LOAD,
  input  wire logic              WIDTH_LOAD,
  input  wire logic              TRAIL_LOAD,
  input  wire logic              EDGE_LOAD,
  input  wire logic [7:0]        PLL_MHZ_IN,
  input  wire logic              PLL_LOAD,
  output logic                   DAC_VALID,
  input  wire logic              DAC_READY,
  output logic [11:0]            DAC_DATA,
  output logic                   FILT_ELLIPTIC,
  output logic                   PULSE_OUT,
  output logic [9:0]             TRAIL_DELAY,
  output logic [7:0]             EDGE_TIME,
  output logic [7:0]             PLL_MHZ
);
  // ---------------------------------------------------------------
  // read address from accumulator
  // ---------------------------------------------------------------
  function automatic logic [15:0] rd_addr(input logic [63:0] acc, input logic deep);
    rd_addr = deep ? acc[63:48] : {2'h0, acc[63:50]};
  endfunction : rd_addr

  dds_pkg::dds_state_t st_ff;
  dds_pkg::dds_pcfg_t  pend_ff;
  dds_pkg::dds_pcfg_t  act_ff;
  logic [63:0] acc_ff;
  logic [63:0] inc_ff;
  logic        deep_ff;
  logic [11:0] mem [0:65535];
  logic [11:0] smp_ff;
  logic        smp_vld_ff;
  logic        sq_cmp_ff;
  logic [11:0] buf_ff [0:1];
  logic        wp_ff;
  logic        rp_ff;
  logic [1:0]  cnt_ff;
  logic [15:0] fa_ff;
  logic [17:0] frac_ff;
  logic [11:0] cur_ff;
  logic        have_ff;
  logic [31:0] pc_ff;
  logic        pulse_ff;
  logic        filt_ff;
  logic [7:0]  pll_ff;
  logic        deep_use;
  logic        in_rdy;
  logic        adv;
  logic        push;
  logic        pop;
  logic [11:0] lvl;
  logic [17:0] nxt_frac;
  logic [17:0] depth;
  logic        fill_last;
  logic        fill_wr;
  logic [63:0] nxt_inc;
  logic [31:0] wid_eff;

  assign deep_use = deep_ff && (FUNC == dds_pkg::FN_ARB);
  assign depth    = deep_ff ? 18'(dds_pkg::DEPTH_L) : 18'(dds_pkg::DEPTH_S);

  // ---------------------------------------------------------------
  // control state
  // ---------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      st_ff <= dds_pkg::ST_IDLE;
    end else begin
      case (st_ff)
        dds_pkg::ST_IDLE: begin
          if (LD_START) begin
            st_ff <= dds_pkg::ST_FILL;
          end else if (RUN && FUNC == dds_pkg::FN_PULSE) begin
            st_ff <= dds_pkg::ST_PULSE;
          end else if (RUN) begin
            st_ff <= dds_pkg::ST_DDS;
          end
        end
        dds_pkg::ST_FILL: begin
          if (fill_last) begin
            st_ff <= dds_pkg::ST_IDLE;
          end
        end
        dds_pkg::ST_DDS: begin
          if (LD_START) begin
            st_ff <= dds_pkg::ST_FILL;
          end else if (!RUN || FUNC == dds_pkg::FN_PULSE) begin
            st_ff <= dds_pkg::ST_IDLE;
          end
        end
        dds_pkg::ST_PULSE: begin
          if (LD_START) begin
            st_ff <= dds_pkg::ST_FILL;
          end else if (!RUN || FUNC != dds_pkg::FN_PULSE) begin
            st_ff <= dds_pkg::ST_IDLE;
          end
        end
        default: st_ff <= dds_pkg::ST_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // memory fill, repeats points to one full cycle
  // ---------------------------------------------------------------
  assign LD_BUSY   = (st_ff == dds_pkg::ST_FILL);
  assign LD_READY  = LD_BUSY && !have_ff;
  assign fill_wr   = LD_BUSY && have_ff;
  assign fill_last = fill_wr && (18'(fa_ff) == depth - 18'h1);
  assign nxt_frac  = frac_ff + 18'(LD_POINTS);

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      deep_ff <= 1'b0;
    end else if (LD_START && !LD_BUSY) begin
      deep_ff <= (LD_POINTS > 17'(dds_pkg::DEPTH_S));
    end
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST || !LD_BUSY) begin
      fa_ff   <= 16'h0000;
      frac_ff <= 18'h00000;
      have_ff <= 1'b0;
      cur_ff  <= 12'h000;
    end else if (!have_ff) begin
      if (LD_VALID) begin
        cur_ff  <= LD_DATA;
        have_ff <= 1'b1;
      end
    end else begin
      fa_ff <= fa_ff + 16'h0001;
      if (nxt_frac >= depth) begin
        frac_ff <= nxt_frac - depth;
        have_ff <= 1'b0;
      end else begin
        frac_ff <= nxt_frac;
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (fill_wr) begin
      mem[fa_ff] <= cur_ff;
    end
  end

  // ---------------------------------------------------------------
  // phase accumulator
  // ---------------------------------------------------------------
  assign nxt_inc = (FUNC == dds_pkg::FN_ARB && PHASE_INCREMENT_VALUE > dds_pkg::INC_ARB_MAX)
                   ? dds_pkg::INC_ARB_MAX : PHASE_INCREMENT_VALUE;

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      inc_ff <= 64'h0000_0000_0000_0000;
    end else if (PHASE_LOAD) begin
      inc_ff <= nxt_inc;
    end
  end

  assign adv = (st_ff == dds_pkg::ST_DDS) && (in_rdy || !smp_vld_ff);

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      acc_ff <= 64'h0000_0000_0000_0000;
    end else if (adv) begin
      acc_ff <= acc_ff + inc_ff;
    end
  end

  // ---------------------------------------------------------------
  // sample read and square comparator
  // ---------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      smp_ff     <= 12'h000;
      smp_vld_ff <= 1'b0;
      sq_cmp_ff  <= 1'b0;
    end else if (adv) begin
      smp_ff     <= mem[rd_addr(acc_ff, deep_use)];
      smp_vld_ff <= 1'b1;
      sq_cmp_ff  <= (FUNC == dds_pkg::FN_SQUARE) && (inc_ff > dds_pkg::INC_SQ_CMP);
    end else if (st_ff != dds_pkg::ST_DDS) begin
      smp_vld_ff <= 1'b0;
    end
  end

  // above 2 MHz threshold compare, below plain memory shape
  assign lvl = !sq_cmp_ff ? smp_ff :
               (smp_ff >= SQ_THRESHOLD) ? dds_pkg::LVL_MAX : dds_pkg::LVL_MIN;

  // ---------------------------------------------------------------
  // two-entry buffer toward the converter
  // ---------------------------------------------------------------
  assign in_rdy    = (cnt_ff != 2'h2);
  assign push      = smp_vld_ff && in_rdy && (st_ff == dds_pkg::ST_DDS);
  assign DAC_VALID = (cnt_ff != 2'h0);
  assign pop       = DAC_VALID && DAC_READY;
  assign DAC_DATA  = buf_ff[rp_ff];

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_buf
      always_ff @(posedge MCLK) begin
        if (SYS_RST) begin
          buf_ff[gi] <= 12'h000;
        end else if (push && wp_ff == 1'(gi)) begin
          buf_ff[gi] <= lvl;
        end
      end
    end
  endgenerate

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      wp_ff  <= 1'b0;
      rp_ff  <= 1'b0;
      cnt_ff <= 2'h0;
    end else begin
      wp_ff  <= wp_ff ^ push;
      rp_ff  <= rp_ff ^ pop;
      cnt_ff <= cnt_ff + 2'(push) - 2'(pop);
    end
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      filt_ff <= 1'b0;
    end else begin
      filt_ff <= (st_ff == dds_pkg::ST_DDS) && (FUNC == dds_pkg::FN_SINE);
    end
  end
  assign FILT_ELLIPTIC = filt_ff;

  // ---------------------------------------------------------------
  // pulse generator
  // ---------------------------------------------------------------
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      pend_ff <= '{dds_pkg::PER_RST, dds_pkg::WID_RST, 10'h000, 8'h00};
    end else begin
      if (PERIOD_LOAD) pend_ff.period <= PULSE_CFG.period;
      if (WIDTH_LOAD) pend_ff.width <= PULSE_CFG.width;
      if (TRAIL_LOAD) pend_ff.trail <= (PULSE_CFG.trail > dds_pkg::TRL_MAX)
                                       ? dds_pkg::TRL_MAX : PULSE_CFG.trail;
      if (EDGE_LOAD) pend_ff.edge_t <= PULSE_CFG.edge_t;
    end
  end

  assign wid_eff = (act_ff.width >= act_ff.period) ? act_ff.period - 32'h1 : act_ff.width;

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      act_ff   <= '{dds_pkg::PER_RST, dds_pkg::WID_RST, 10'h000, 8'h00};
      pc_ff    <= 32'h0000_0000;
      pulse_ff <= 1'b0;
    end else if (st_ff != dds_pkg::ST_PULSE) begin
      act_ff   <= pend_ff;
      pc_ff    <= 32'h0000_0000;
      pulse_ff <= 1'b0;
    end else begin
      pulse_ff <= (pc_ff < wid_eff);
      if (pc_ff >= act_ff.period - 32'h1) begin
        pc_ff  <= 32'h0000_0000;
        act_ff <= pend_ff;
      end else begin
        pc_ff <= pc_ff + 32'h1;
      end
    end
  end
  assign PULSE_OUT   = pulse_ff;
  assign TRAIL_DELAY = act_ff.trail;
  assign EDGE_TIME   = act_ff.edge_t;

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      pll_ff <= dds_pkg::PLL_MAX;
    end else if (PLL_LOAD) begin
      pll_ff <= (PLL_MHZ_IN < dds_pkg::PLL_MIN) ? dds_pkg::PLL_MIN :
                (PLL_MHZ_IN > dds_pkg::PLL_MAX) ? dds_pkg::PLL_MAX : PLL_MHZ_IN;
    end
  end
  assign PLL_MHZ = pll_ff;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SYS_RST);

  a_acc_step: assert property (adv |=> acc_ff == $past(acc_ff) + $past(inc_ff))
    else $error("accumulator did not add increment");
  a_inc_load: assert property (PHASE_LOAD && FUNC != dds_pkg::FN_ARB
    |=> inc_ff == $past(PHASE_INCREMENT_VALUE))
    else $error("increment not loaded");
  a_arb_limit: assert property (PHASE_LOAD && FUNC == dds_pkg::FN_ARB
    |=> inc_ff <= dds_pkg::INC_ARB_MAX)
    else $error("arbitrary rate over limit");
  a_addr_short: assert property (adv && !deep_use
    |=> smp_ff == $past(mem[{2'h0, acc_ff[63:50]}]))
    else $error("short address wrong");
  a_sq_level: assert property (push && sq_cmp_ff
    |=> buf_ff[$past(wp_ff)] == dds_pkg::LVL_MAX || buf_ff[$past(wp_ff)] == dds_pkg::LVL_MIN)
    else $error("square level not binary");
  a_pulse_high: assert property (st_ff == dds_pkg::ST_PULSE && pc_ff == 32'h0
    && wid_eff != 32'h0 ##1 st_ff == dds_pkg::ST_PULSE |-> PULSE_OUT)
    else $error("pulse not high at period start");
  a_pulse_low: assert property (st_ff == dds_pkg::ST_PULSE && pc_ff >= wid_eff
    ##1 st_ff == dds_pkg::ST_PULSE |-> !PULSE_OUT)
    else $error("pulse high past width");
  a_pll_range: assert property (PLL_LOAD |=> PLL_MHZ >= dds_pkg::PLL_MIN
    && PLL_MHZ <= dds_pkg::PLL_MAX)
    else $error("pulse clock out of range");
  a_trail_max: assert property (TRAIL_LOAD |=> pend_ff.trail <= dds_pkg::TRL_MAX)
    else $error("trailing delay over range");
  a_filt_sel: assert property (st_ff == dds_pkg::ST_DDS && FUNC == dds_pkg::FN_SINE
    |=> FILT_ELLIPTIC)
    else $error("sine not on elliptic path");
  a_buf_hold: assert property (DAC_VALID && !DAC_READY |=> DAC_VALID && $stable(DAC_DATA))
    else $error("converter word lost");

  c_stream: cover property (pop [*4]);
  c_full: cover property (cnt_ff == 2'h2);
  c_fill: cover property (fill_last);
  c_pulse: cover property (PULSE_OUT ##1 !PULSE_OUT ##[1:20] PULSE_OUT);
endmodule : dds_core

// ---- dds_dac_model.sv ----
// converter-side model: takes samples, can stall every third cycle
`timescale 1ns/1ns
module dds_dac_model (
  input  wire logic        clk,
  input  wire logic        valid,
  input  wire logic [11:0] data,
  output logic             ready,
  input  wire logic        stall_en
);
  logic [11:0] words[$];
  int          cyc_ff;
  initial ready = 1'b0;
  initial cyc_ff = 0;
  // one word taken per accepted sample, ready moves just after the edge
  always @(posedge clk) begin
    if (valid && ready) words.push_back(data);
    cyc_ff <= cyc_ff + 1;
    ready <= #1 !(stall_en && (cyc_ff % 3 == 0));
  end
endmodule : dds_dac_model

// ---- tb.sv ----
// testbench for the dds core
`timescale 1ns/1ns
module tb;
  logic                clk, rst, run, ph_ld, ld_start, ld_valid, ld_ready, ld_busy, stall;
  logic                per_ld, wid_ld, trl_ld, edg_ld, pll_ld, dac_valid, dac_ready, filt;
  logic                pulse_out;
  dds_pkg::dds_func_t  func;
  logic [63:0]         inc_v;
  logic [11:0]         sq_thr, ld_data, dac_data;
  logic [16:0]         ld_points;
  dds_pkg::dds_pcfg_t  pcfg;
  logic [7:0]          pll_in, edge_time, pll_mhz;
  logic [9:0]          trail;
  int                  n_errors, tests_run;

  dds_core uut (.MCLK(clk), .SYS_RST(rst), .FUNC(func), .RUN(run),
    .PHASE_INCREMENT_VALUE(inc_v), .PHASE_LOAD(ph_ld), .SQ_THRESHOLD(sq_thr),
    .LD_START(ld_start), .LD_POINTS(ld_points), .LD_VALID(ld_valid), .LD_READY(ld_ready),
    .LD_DATA(ld_data), .LD_BUSY(ld_busy), .PULSE_CFG(pcfg), .PERIOD_LOAD(per_ld),
    .WIDTH_LOAD(wid_ld), .TRAIL_LOAD(trl_ld), .EDGE_LOAD(edg_ld), .PLL_MHZ_IN(pll_in),
    .PLL_LOAD(pll_ld), .DAC_VALID(dac_valid), .DAC_READY(dac_ready), .DAC_DATA(dac_data),
    .FILT_ELLIPTIC(filt), .PULSE_OUT(pulse_out), .TRAIL_DELAY(trail),
    .EDGE_TIME(edge_time), .PLL_MHZ(pll_mhz));
  dds_dac_model dac (.clk(clk), .valid(dac_valid), .data(dac_data), .ready(dac_ready),
    .stall_en(stall));

  always #4 clk = ~clk;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  task automatic chk(input bit good, input string m);
    tests_run++;
    if (!good) begin
      n_errors++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask : chk

  task automatic summarize;
    $display("comparisons %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize

  task automatic collect(input int n);
    int w;
    w = 0;
    while (dac.words.size() < n && w < 1000) begin
      step(1);
      w++;
    end
    chk(dac.words.size() >= n, "sample stream stopped");
  endtask : collect

  function automatic int bad_steps(input logic [11:0] d);
    int b;
    b = 0;
    for (int i = 1; i < dac.words.size(); i++)
      if (12'(dac.words[i] - dac.words[i-1]) !== d) b++;
    return b;
  endfunction : bad_steps

  task automatic play(input dds_pkg::dds_func_t f, input logic [63:0] inc, input bit st);
    rst = 1'b1;
    run = 1'b0;
    step(2);
    rst = 1'b0;
    func = f;
    stall = st;
    inc_v = inc;
    ph_ld = 1'b1;
    step(1);
    ph_ld = 1'b0;
    run = 1'b1;
    dac.words.delete();
    collect(40);
  endtask : play

  task automatic measure(output int hi, output int per);
    int w;
    w = 0;
    while (pulse_out !== 1'b1 && w < 200) begin
      step(1);
      w++;
    end
    hi = 0;
    while (pulse_out === 1'b1 && hi < 200) begin
      step(1);
      hi++;
    end
    per = hi;
    while (pulse_out !== 1'b1 && per < 200) begin
      step(1);
      per++;
    end
  endtask : measure

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_fill(input int n, input int scale);
    int w;
    func = dds_pkg::FN_STD;
    ld_points = 17'(n);
    ld_start = 1'b1;
    step(1);
    ld_start = 1'b0;
    for (int i = 0; i < n; i++) begin
      ld_valid = 1'b1;
      ld_data = 12'(i * scale);
      w = 0;
      while (ld_ready !== 1'b1 && w < 5000) begin
        step(1);
        w++;
      end
      step(1);
    end
    ld_valid = 1'b0;
    w = 0;
    while (ld_busy !== 1'b0 && w < 5000) begin
      step(1);
      w++;
    end
    chk(ld_busy === 1'b0, "fill never ended");
  endtask : t_fill

  task automatic t_rate;
    int b, n0;
    bit seen2;
    logic [11:0] d;
    play(dds_pkg::FN_STD, 64'h0004_0000_0000_0000, 1'b1);
    chk(bad_steps(12'h001) == 0, "address step with stalls");
    inc_v = 64'h0008_0000_0000_0000;
    ph_ld = 1'b1;
    step(1);
    ph_ld = 1'b0;
    n0 = dac.words.size();
    collect(n0 + 40);
    b = 0;
    seen2 = 1'b0;
    for (int i = 1; i < dac.words.size(); i++) begin
      d = 12'(dac.words[i] - dac.words[i-1]);
      if (d === 12'h002) seen2 = 1'b1;
      else if (d !== 12'h001 || seen2) b++;
    end
    chk(b == 0 && seen2, "phase jump on rate change");
  endtask : t_rate

  task automatic t_modes;
    int b, hi_n, lo_n;
    play(dds_pkg::FN_STD, 64'h8004_0000_0000_0000, 1'b0);
    chk(bad_steps(12'h001) == 0, "accumulator wrap");
    play(dds_pkg::FN_ARB, 64'h8000_0000_0000_0000, 1'b0);
    chk(bad_steps(12'h800) == 0, "arbitrary rate not limited");
    chk(filt === 1'b0, "filter for arbitrary");
    play(dds_pkg::FN_SINE, 64'h0004_0000_0000_0000, 1'b0);
    chk(filt === 1'b1, "filter for sine");
    play(dds_pkg::FN_SQUARE, 64'h0004_0000_0000_0000, 1'b0);
    chk(bad_steps(12'h001) == 0, "slow square not from memory");
    play(dds_pkg::FN_SQUARE, 64'h0400_0000_0000_0000, 1'b0);
    b = 0;
    hi_n = 0;
    lo_n = 0;
    foreach (dac.words[i]) begin
      if (dac.words[i] === 12'hFFF) hi_n++;
      else if (dac.words[i] === 12'h000) lo_n++;
      else b++;
      if (dac.words[i] !== (((i % 16) >= 8) ? 12'hFFF : 12'h000)) b++;
    end
    chk(b == 0 && hi_n > 0 && lo_n > 0, "fast square levels");
  endtask : t_modes

  task automatic t_stretch;
    int b;
    t_fill(4, 256);
    play(dds_pkg::FN_STD, 64'h1000_0000_0000_0000, 1'b0);
    b = 0;
    foreach (dac.words[i])
      if (dac.words[i] !== 12'(256 * ((i / 4) % 4))) b++;
    chk(b == 0, "short wave not stretched by repetition");
  endtask : t_stretch

  task automatic t_pulse;
    int hi, per;
    rst = 1'b1;
    run = 1'b0;
    step(2);
    rst = 1'b0;
    chk(pll_mhz === 8'hC8 && trail === 10'h000 && pulse_out === 1'b0, "reset");
    func = dds_pkg::FN_PULSE;
    pcfg = '{period: 32'h0000_000A, width: 32'h0000_0003, trail: 10'h3FF, edge_t: 8'h5A};
    per_ld = 1'b1;
    wid_ld = 1'b1;
    step(1);
    per_ld = 1'b0;
    wid_ld = 1'b0;
    run = 1'b1;
    measure(hi, per);
    chk(hi == 3 && per == 10, "pulse width or period");
    trl_ld = 1'b1;
    edg_ld = 1'b1;
    pll_ld = 1'b1;
    pll_in = 8'h32;
    step(1);
    chk(pll_mhz === 8'h64, "pulse clock low clamp");
    trl_ld = 1'b0;
    edg_ld = 1'b0;
    pll_in = 8'hFF;
    step(1);
    pll_ld = 1'b0;
    step(12);
    chk(trail === 10'h3E8, "trail delay clamp");
    chk(edge_time === 8'h5A, "edge time");
    chk(pll_mhz === 8'hC8, "pulse clock high clamp");
    measure(hi, per);
    chk(hi == 3 && per == 10, "timing moved by other fields");
  endtask : t_pulse

  initial begin
    {clk, run, ph_ld, ld_start, ld_valid, stall, per_ld, wid_ld, trl_ld, edg_ld} = '0;
    {pll_ld, n_errors, tests_run} = '0;
    func = dds_pkg::FN_STD;
    inc_v = 64'h0;
    sq_thr = 12'h800;
    ld_points = 17'h04000;
    ld_data = 12'h000;
    pcfg = '0;
    pll_in = 8'hC8;
    rst = 1'b1;
    step(20);
    rst = 1'b0;
    step(1);
    chk(dac_valid === 1'b0 && ld_busy === 1'b0 && filt === 1'b0, "reset outputs");
    t_fill(16384, 1);
    t_rate();
    t_modes();
    t_stretch();
    t_pulse();
    summarize();
  end

  initial begin
    #(8 * 70000);
    n_errors++;
    summarize();
  end
endmodule : tb
